// [core/bpwm_cfg.svh]
// register offsets, field positions, reset values and mode encodings of the pwm timer
`ifndef BPWM_CFG_SVH
`define BPWM_CFG_SVH

`define BPWM_NCH            6
`define BPWM_AW             5
// register map (byte-free word index on the plain port)
`define BPWM_A_TSC          5'h00
`define BPWM_A_MOD          5'h01
`define BPWM_A_CNT          5'h02
`define BPWM_A_IRQ          5'h03
`define BPWM_A_CSC0         5'h08
`define BPWM_A_CVAL0        5'h10
// timer status/control field positions
`define BPWM_TSC_PS_LO      0
`define BPWM_TSC_RST        4
`define BPWM_TSC_HALT       5
`define BPWM_TSC_WIE        6
`define BPWM_TSC_WF         7
// channel status/control field positions
`define BPWM_CSC_FULL       0
`define BPWM_CSC_TOV        1
`define BPWM_CSC_ELS_LO     2
`define BPWM_CSC_MS_LO      4
`define BPWM_CSC_IE         6
`define BPWM_CSC_F          7
// reset values
`define BPWM_MOD_RST        16'hffff
`define BPWM_CSC_RST        8'h00
// mode and output action encodings
`define BPWM_MS_UNBUF       2'h1
`define BPWM_MS_BUF         2'h2
`define BPWM_ELS_CLR        2'h2
`define BPWM_ELS_SET        2'h3
`define BPWM_ELS_TGL        2'h1

`endif

// [core/bpwm_pkg.sv]
// types shared by the pwm timer modules
package bpwm_pkg;

    typedef struct packed {
        logic        full;
        logic        tov;
        logic [1:0]  els;
        logic [1:0]  ms;
        logic        ie;
    } bpwm_csc_t;

    typedef struct packed {
        logic        halt;
        logic        wie;
        logic        wf;
        logic [2:0]  ps;
    } bpwm_tsc_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } bpwm_bus_t;

    typedef enum logic [1:0] {
        BPWM_PIN_IDLE = 2'b00,
        BPWM_PIN_ON   = 2'b01
    } bpwm_pin_t;

endpackage

// [core/bpwm_prescale.sv]
// counter prescaler: tick every 2**ps bus clocks, clearable
`timescale 1ns/1ps
`default_nettype none
module bpwm_prescale
    import bpwm_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       clr_i,
    input  wire logic       run_i,
    input  wire logic [2:0] ps_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [6:0] div;
        logic       tick;
    } bpwm_ps_st_t;

    bpwm_ps_st_t st_r;
    bpwm_ps_st_t st_nxt;
    logic [6:0]  lim;

    always_comb
    begin
        lim    = 7'(({7{1'b0}} | 7'h01) << ps_i) - 7'h01;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clr_i)
        begin
            st_nxt.div = 7'h00;
        end
        else if (run_i)
        begin
            if (st_r.div >= lim)
            begin
                st_nxt.div  = 7'h00;
                st_nxt.tick = 1'b1;
            end
            else
            begin
                st_nxt.div = st_r.div + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule // bpwm_prescale
`default_nettype wire

// [core/bpwm_timer.sv]
// six-channel 16-bit pwm timer with buffered channel pairs
`timescale 1ns/1ps
`default_nettype none
`include "bpwm_cfg.svh"
// Notes on behaviour
// - unbuffered channel compares to its own value; writes take effect at once
// - compare fires only on equality; values skipped past give no compare
// - channel compare ends the pulse and sets the channel flag
// - wrap event ends the period and sets the wrap flag
// - link bit on channel 0/2/4 pairs with next odd channel; even pin drives
// - even value controls first; odd write takes over at next period start
// - at each later wrap the most recently written set becomes active
// - even control register runs the pair; odd pin released to gpio
// - mode field 01 selects unbuffered, 10 selects buffered
// - output action 10 drives low on compare, 11 drives high
// - toggle-at-wrap set toggles output at each wrap
// - high mode bit on even channels overrides the low mode bit
// - toggle-at-wrap clear with output action 10 gives no wrap toggle, so zero duty
// - full-duty with toggle-at-wrap gives continuous full duty; with output action 11 it holds the pin low
// - wrap flag set at modulo; irq only while wrap irq enable set
// - channel flag set on compare; irq only while channel enable set
// - timer runs in wait mode; enabled irq asserts wake request
// - halt bit stops counting; reset sets it
// - counter reset bit clears counter and prescaler, reads zero
// - at modulo the counter sets wrap flag and restarts from zero
// - pulse runs wrap to compare; period is wrap to wrap
module bpwm_timer
    import bpwm_pkg::*;
#(
    parameter int NCH = `BPWM_NCH
)
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    input  wire logic [`BPWM_AW-1:0] addr_i,
    input  wire logic [15:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    input  wire logic                wait_i,
    output logic      [15:0]         rdata_o,
    output logic      [NCH-1:0]      ch_pin_o,
    output logic      [NCH-1:0]      ch_pin_oe_o,
    output logic                     irq_o,
    output logic                     wake_o
);
    typedef struct packed {
        bpwm_tsc_t           tsc;
        logic [15:0]         modv;
        logic [15:0]         cnt;
        bpwm_csc_t [NCH-1:0] csc;
        logic [NCH-1:0]      cf;
        logic [NCH-1:0][15:0] val;
        logic [NCH-1:0]      pin;
        logic [NCH-1:0]      oe;
        logic [2:0]          sel_odd;
        logic [2:0]          pend_odd;
        logic [2:0]          link_q;
        logic                wf_rd;
        logic [NCH-1:0]      cf_rd;
        logic [15:0]         rdata;
        logic                irq;
        logic                wake;
    } bpwm_st_t;

    bpwm_st_t   st_r;
    bpwm_st_t   st_nxt;
    logic       tick;
    logic       clr_ps;
    logic       wrap;
    logic [NCH-1:0] cmp;
    logic [2:0] link;
    logic       any_irq;

    function automatic logic is_linked(input bpwm_csc_t c);
        is_linked = c.ms[1];
    endfunction

    function automatic logic pwm_mode(input bpwm_csc_t c, input logic even);
        pwm_mode = (c.ms == `BPWM_MS_UNBUF) || (even && c.ms[1]);
    endfunction

    assign clr_ps = wr_i && (addr_i == `BPWM_A_TSC) && wdata_i[`BPWM_TSC_RST];

    bpwm_prescale u_ps
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .clr_i     (clr_ps),
        .run_i     (!st_r.tsc.halt),
        .ps_i      (st_r.tsc.ps),
        .tick_o    (tick)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdata = 16'h0000;
        for (int p = 0; p < 3; p++)
        begin
            link[p] = is_linked(st_r.csc[2*p]);
        end
        wrap = tick && (st_r.cnt == st_r.modv);
        for (int c = 0; c < NCH; c++)
        begin
            logic [15:0] v;
            v = st_r.val[c];
            if ((c % 2 == 0) && link[c/2] && st_r.sel_odd[c/2])
            begin
                v = st_r.val[c | 1];
            end
            cmp[c] = tick && (st_r.cnt == v);
        end
        // counter
        if (tick)
        begin
            st_nxt.cnt = wrap ? 16'h0000 : st_r.cnt + 16'h0001;
        end
        if (wrap)
        begin
            st_nxt.tsc.wf = 1'b1;
        end
        // pair selection
        for (int p = 0; p < 3; p++)
        begin
            st_nxt.link_q[p] = link[p];
            if (link[p] && !st_r.link_q[p])
            begin
                st_nxt.sel_odd[p]  = 1'b0;
                st_nxt.pend_odd[p] = 1'b0;
            end
            else if (wrap)
            begin
                st_nxt.sel_odd[p] = st_r.pend_odd[p];
            end
        end
        // channel outputs and flags
        for (int c = 0; c < NCH; c++)
        begin
            logic odd_free;
            logic act;
            logic nv;
            odd_free = (c % 2 == 1) && link[c/2];
            act = pwm_mode(st_r.csc[c], c % 2 == 0) && !odd_free;
            st_nxt.oe[c] = act;
            nv = st_r.pin[c];
            if (act && wrap && st_r.csc[c].tov)
            begin
                nv = !nv;
            end
            if (act && cmp[c])
            begin
                st_nxt.cf[c] = 1'b1;
                case (st_r.csc[c].els)
                    `BPWM_ELS_CLR: nv = 1'b0;
                    `BPWM_ELS_SET: nv = 1'b1;
                    `BPWM_ELS_TGL: nv = !st_r.pin[c];
                    default:       nv = nv;
                endcase
            end
            if (act && st_r.csc[c].full && st_r.csc[c].tov)
            begin
                nv = (st_r.csc[c].els == `BPWM_ELS_SET) ? 1'b0 : 1'b1;
            end
            st_nxt.pin[c] = nv;
        end
        // register reads: flags cleared by read then write of zero
        if (rd_i)
        begin
            case (addr_i)
                `BPWM_A_TSC:
                begin
                    st_nxt.rdata = {8'h00, st_r.tsc.wf, st_r.tsc.wie, st_r.tsc.halt, 1'b0, 1'b0,
                                    st_r.tsc.ps};
                    st_nxt.wf_rd = st_r.tsc.wf;
                end
                `BPWM_A_MOD: st_nxt.rdata = st_r.modv;
                `BPWM_A_CNT: st_nxt.rdata = st_r.cnt;
                `BPWM_A_IRQ: st_nxt.rdata = {9'h000, st_r.irq, st_r.cf};
                default:
                begin
                    for (int c = 0; c < NCH; c++)
                    begin
                        if (addr_i == `BPWM_A_CSC0 + 5'(c))
                        begin
                            st_nxt.rdata = {8'h00, st_r.cf[c], st_r.csc[c].ie, st_r.csc[c].ms,
                                            st_r.csc[c].els, st_r.csc[c].tov, st_r.csc[c].full};
                            st_nxt.cf_rd[c] = st_r.cf[c];
                        end
                        if (addr_i == `BPWM_A_CVAL0 + 5'(c))
                        begin
                            st_nxt.rdata = st_r.val[c];
                        end
                    end
                end
            endcase
        end
        if (wr_i)
        begin
            case (addr_i)
                `BPWM_A_TSC:
                begin
                    st_nxt.tsc.ps   = wdata_i[`BPWM_TSC_PS_LO +: 3];
                    st_nxt.tsc.halt = wdata_i[`BPWM_TSC_HALT];
                    st_nxt.tsc.wie  = wdata_i[`BPWM_TSC_WIE];
                    if (!wdata_i[`BPWM_TSC_WF] && st_r.wf_rd && !wrap)
                    begin
                        st_nxt.tsc.wf = 1'b0;
                    end
                    st_nxt.wf_rd = 1'b0;
                    if (wdata_i[`BPWM_TSC_RST])
                    begin
                        st_nxt.cnt = 16'h0000;
                    end
                end
                `BPWM_A_MOD: st_nxt.modv = wdata_i;
                default:
                begin
                    for (int c = 0; c < NCH; c++)
                    begin
                        if (addr_i == `BPWM_A_CSC0 + 5'(c))
                        begin
                            st_nxt.csc[c].full = wdata_i[`BPWM_CSC_FULL];
                            st_nxt.csc[c].tov  = wdata_i[`BPWM_CSC_TOV];
                            st_nxt.csc[c].els  = wdata_i[`BPWM_CSC_ELS_LO +: 2];
                            st_nxt.csc[c].ms   = wdata_i[`BPWM_CSC_MS_LO +: 2];
                            st_nxt.csc[c].ie   = wdata_i[`BPWM_CSC_IE];
                            if (!wdata_i[`BPWM_CSC_F] && st_r.cf_rd[c] && !cmp[c])
                            begin
                                st_nxt.cf[c] = 1'b0;
                            end
                            st_nxt.cf_rd[c] = 1'b0;
                        end
                        if (addr_i == `BPWM_A_CVAL0 + 5'(c))
                        begin
                            st_nxt.val[c] = wdata_i;
                            if (link[c/2])
                            begin
                                st_nxt.pend_odd[c/2] = (c % 2 == 1);
                            end
                        end
                    end
                end
            endcase
        end
        any_irq = st_nxt.tsc.wf && st_nxt.tsc.wie;
        for (int c = 0; c < NCH; c++)
        begin
            if (st_nxt.cf[c] && st_nxt.csc[c].ie && !((c % 2 == 1) && link[c/2]))
            begin
                any_irq = 1'b1;
            end
        end
        st_nxt.irq  = any_irq;
        st_nxt.wake = any_irq && wait_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_r          <= '0;
            st_r.tsc.halt <= 1'b1;
            st_r.modv     <= `BPWM_MOD_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o     = st_r.rdata;
    assign ch_pin_o    = st_r.pin;
    assign ch_pin_oe_o = st_r.oe;
    assign irq_o       = st_r.irq;
    assign wake_o      = st_r.wake;
endmodule // bpwm_timer
`default_nettype wire

// [verif/bpwm_load_model.sv]
// load on one pwm pin: measures pulse length, period and total high time
`timescale 1ns/1ps
`default_nettype none
module bpwm_load_model
(
    input  wire logic        clk_sys_i,
    input  wire logic        pin_i,
    input  wire logic        oe_i,
    output logic      [15:0] hi_len_o = 16'h0,
    output logic      [15:0] per_len_o = 16'h0,
    output logic      [15:0] hi_tot_o = 16'h0
);
    logic        lvl;
    logic        lvl_q = 1'b0;
    logic [15:0] hi_c = 16'h0;
    logic [15:0] per_c = 16'h0;

    // a released pin is pulled down by the load
    assign lvl = oe_i & pin_i;

    always @(posedge clk_sys_i)
    begin
        lvl_q <= lvl;
        hi_tot_o <= hi_tot_o + {15'h0, lvl};
        if (lvl && !lvl_q)
        begin
            per_len_o <= per_c;
            per_c <= 16'h1;
            hi_c <= 16'h1;
        end
        else
        begin
            per_c <= per_c + 16'h1;
            if (lvl)
                hi_c <= hi_c + 16'h1;
        end
        if (!lvl && lvl_q)
            hi_len_o <= hi_c;
    end
endmodule // bpwm_load_model
`default_nettype wire

// [verif/bpwm_timer_properties.sv]
// assertions on the pwm timer ports
`timescale 1ns/1ps
`default_nettype none
module bpwm_timer_properties
    import bpwm_pkg::*;
#(
    parameter int NCH = 6
)
(
    input wire logic           clk_sys_i,
    input wire logic           rst_i,
    input wire logic [4:0]     addr_i,
    input wire logic [15:0]    wdata_i,
    input wire logic           wr_i,
    input wire logic           rd_i,
    input wire logic           wait_i,
    input wire logic [15:0]    rdata_o,
    input wire logic [NCH-1:0] ch_pin_o,
    input wire logic [NCH-1:0] ch_pin_oe_o,
    input wire logic           irq_o,
    input wire logic           wake_o
);
    logic        halt_r, lk_r, full_r;
    logic [6:0]  ie_r;
    logic [15:0] mod_r;

    // shadow of the control bits written over the bus
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            halt_r <= 1'b1;
            lk_r   <= 1'b0;
            full_r <= 1'b0;
            ie_r   <= 7'h00;
            mod_r  <= 16'hffff;
        end
        else if (wr_i)
        begin
            if (addr_i == 5'h00)
            begin
                halt_r  <= wdata_i[5];
                ie_r[6] <= wdata_i[6];
            end
            if (addr_i == 5'h01)
                mod_r <= wdata_i;
            if (addr_i == 5'h08)
            begin
                lk_r   <= wdata_i[5];
                full_r <= wdata_i[1] & wdata_i[0] & (wdata_i[3:2] != 2'h3) & (wdata_i[5:4] != 2'h0);
            end
            if (addr_i[4:3] == 2'h1 && addr_i[2:0] < 3'h6)
                ie_r[addr_i[2:0]] <= wdata_i[6];
        end
    end

    default clocking dcb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    chk_rst_bit_zero:
        assert property ($past(rd_i) && $past(addr_i) == 5'h00 |-> !rdata_o[4]) else $error("counter reset bit read 1");
    chk_halt_read:
        assert property ($past(rd_i) && $past(addr_i) == 5'h00 |-> rdata_o[5] == $past(halt_r))
        else $error("halt bit read wrong");
    chk_cnt_bound:
        assert property ($past(rd_i) && $past(addr_i) == 5'h02 |-> rdata_o <= $past(mod_r))
        else $error("counter above modulo");
    chk_cnt_clear:
        assert property (wr_i && addr_i == 5'h00 && wdata_i[5:4] == 2'h3 ##[1:3] rd_i && addr_i == 5'h02
            |=> rdata_o == 16'h0000) else $error("counter not cleared");
    chk_wake_irq:
        assert property (wake_o == (irq_o && $past(wait_i))) else $error("wake differs from irq in wait");
    chk_irq_enable:
        assert property (ie_r == 7'h00 |-> !irq_o) else $error("irq without enable");
    chk_odd_release:
        assert property ($past(lk_r) |-> !ch_pin_oe_o[1] && ch_pin_oe_o[0]) else $error("linked pair pin drive");
    chk_full_duty:
        assert property (full_r && $past(full_r) && $past(full_r, 2) && $past(full_r, 3) |-> ch_pin_o[0])
        else $error("full duty pin low");

    cover property (wake_o);
    cover property ($past(lk_r) && ch_pin_oe_o[0]);
    cover property (full_r ##3 ch_pin_o[0]);
endmodule // bpwm_timer_properties

bind bpwm_timer bpwm_timer_properties #(.NCH(NCH)) i_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .wait_i(wait_i), .rdata_o(rdata_o),
    .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire

// [verif/bpwm_timer_tb.sv]
// self-checking testbench for the pwm timer
`timescale 1ns/1ps
`default_nettype none
module bpwm_timer_tb;
    localparam logic [15:0] MOD = 16'h0009;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [4:0]  addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        wait_i = 1'b0;
    logic [15:0] rdata_o, hi_len, per_len, hi_tot, snap;
    logic [5:0]  ch_pin_o, ch_pin_oe_o;
    logic        irq_o, wake_o;
    int          failures = 0;
    int          n_compared = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    bpwm_timer #(.NCH(6)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .wait_i(wait_i), .rdata_o(rdata_o), .ch_pin_o(ch_pin_o),
        .ch_pin_oe_o(ch_pin_oe_o), .irq_o(irq_o), .wake_o(wake_o));
    bpwm_load_model i_load (.clk_sys_i(clk_sys_i), .pin_i(ch_pin_o[0]), .oe_i(ch_pin_oe_o[0]),
        .hi_len_o(hi_len), .per_len_o(per_len), .hi_tot_o(hi_tot));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] exp, input string n);
        logic [15:0] v;
        rd(a, v);
        check(n, v, exp);
    endtask
    // halt, clear counter, period, width, mode, then run
    task automatic init(input logic [15:0] csc, input logic [15:0] cv);
        wr(5'h00, 16'h0030);
        wr(5'h01, MOD);
        wr(5'h10, cv);
        wr(5'h08, csc);
        wr(5'h00, 16'h0000);
    endtask
    // let the output settle over four periods, then judge the last pulse;
    // with output action 10 a pulse spans wrap to compare, so it lasts the compare value plus one count
    task automatic pw(input logic [15:0] exp);
        idle(40);
        check("pulse", hi_len, exp);
        check("period", per_len, MOD + 16'h1);
    endtask

    task automatic t_reset;
        rc(5'h00, 16'h0020, "tsc");
        rc(5'h01, 16'hffff, "mod");
        rc(5'h02, 16'h0000, "cnt");
        rc(5'h08, 16'h0000, "csc0");
        wr(5'h1f, 16'h1234);
        rc(5'h1f, 16'h0000, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_unbuf;
        init(16'h005a, 16'h0003);
        wait_i <= 1'b1;
        pw(16'h0004);
        // longer width written in the cycle right after a wrap
        wr(5'h10, 16'h0005);
        rc(5'h08, 16'h00da, "ch flag");
        rc(5'h00, 16'h0080, "wrap flag");
        check("irq", {15'h0, irq_o}, 16'h0001);
        check("wake", {15'h0, wake_o}, 16'h0001);
        pw(16'h0006);
        wr(5'h08, 16'h001a);
        idle(2);
        check("irq off", {15'h0, irq_o}, 16'h0000);
        wait_i <= 1'b0;
        $display("test unbuffered done");
    endtask
    task automatic t_duty;
        init(16'h001e, 16'h0003);
        pw(16'h0006);
        wr(5'h08, 16'h0018);
        idle(20);
        snap = hi_tot;
        idle(30);
        check("zero duty", hi_tot - snap, 16'h0000);
        wr(5'h08, 16'h001b);
        idle(5);
        snap = hi_tot;
        idle(30);
        check("full duty", hi_tot - snap, 16'h001e);
        $display("test duty done");
    endtask
    task automatic t_buf;
        init(16'h003a, 16'h0002);
        pw(16'h0003);
        check("pin drive", {10'h0, ch_pin_oe_o}, 16'h0001);
        wr(5'h11, 16'h0006);
        pw(16'h0007);
        wr(5'h10, 16'h0004);
        pw(16'h0005);
        $display("test buffered done");
    endtask
    task automatic t_halt;
        wr(5'h00, 16'h0020);
        // nothing needed in wait, so the timer is halted first
        wait_i <= 1'b1;
        rd(5'h02, snap);
        idle(5);
        rc(5'h02, snap, "halted cnt");
        wr(5'h00, 16'h0030);
        rc(5'h02, 16'h0000, "cnt clear");
        rd(5'h00, snap);
        check("rst bit", snap & 16'h0030, 16'h0020);
        check("wake halted", {15'h0, wake_o}, 16'h0000);
        wait_i <= 1'b0;
        $display("test halt done");
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset;
        t_unbuf;
        t_duty;
        t_buf;
        t_halt;
        stop_test;
    end
    // cut a hang short well past the expected run length
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        stop_test;
    end
endmodule // bpwm_timer_tb
`default_nettype wire
